// ### design/binput_pkg.sv
// Shared types and constants for the binary input readout channel.
package binput_pkg;

    // Clock and time base.
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_S = 1;
    localparam longint SECOND_CYCLES_DEF = longint'(TICK_TIME_S) * CLK_HZ;

    // Frequencies are carried in hundredths of a hertz.
    localparam int CENTI = 100;
    localparam logic [16:0] MAXF_MIN = 17'h02710;
    localparam logic [16:0] MAXF_MAX = 17'h186a0;

    // Counts per gate at full scale; sets the resolution relative to the maximum.
    localparam logic [10:0] FULL_SCALE = 11'h3e8;

    // Gate ends when the sum of maxFreq per clock reaches this many units.
    localparam longint GATE_UNITS_DEF = longint'(FULL_SCALE) * CENTI * CLK_HZ * TICK_TIME_S;
    // Least spacing between two accepted edges, in the same units.
    localparam longint EDGE_UNITS_DEF = longint'(CENTI) * CLK_HZ * TICK_TIME_S;

    // Range limits in hundredths of the engineering unit.
    localparam logic signed [31:0] LRV_MIN = 32'shfffc_f2c0;
    localparam logic signed [31:0] LRV_MAX = 32'sh0000_0000;
    localparam logic signed [31:0] LRV_RST = 32'sh0000_0000;
    localparam logic signed [31:0] URV_MIN = 32'sh0000_0000;
    localparam logic signed [31:0] URV_MAX = 32'sh000f_4240;
    localparam logic signed [31:0] URV_RST = 32'sh0000_0000;

    // Damping in seconds.
    localparam int DAMP_W = 6;
    localparam logic [5:0] DAMP_MAX = 6'h3c;
    localparam logic [5:0] DAMP_RST = 6'h00;

    // Decimal places and the scale steps used to reach them.
    localparam logic [1:0] DEC_RST = 2'h2;
    localparam logic signed [31:0] STEP_TENTH = 32'sh0000_000a;
    localparam logic signed [31:0] STEP_UNIT = 32'sh0000_0064;

    // Text fields hold this many eight-bit characters.
    localparam int TEXT_CHARS = 16;

    typedef enum logic {SIG_STATIC, SIG_PULSE_FREQ} sig_kind_type;
    typedef enum logic {POL_LOW, POL_HIGH} polarity_type;
    typedef enum logic [1:0] {USE_RANGE_SWITCH, USE_EXT_HOLD, USE_CLEANING, USE_CTRL_ENABLE} trigger_use_type;
    typedef enum logic [1:0] {VAR_FREQUENCY, VAR_PARAMETER, VAR_FLOW} input_var_type;
    typedef enum logic [2:0] {FLOW_L_S, FLOW_L_H, FLOW_M3_S, FLOW_M3_H, FLOW_CFS, FLOW_CFD, FLOW_MGD} flow_unit_type;

    typedef logic [8*TEXT_CHARS-1:0] text_type;

    typedef struct packed {
        logic enable;
        sig_kind_type sigKind;
        polarity_type polarity;
        trigger_use_type triggerUse;
        logic [16:0] maxFreq;
        logic [1:0] decimals;
        input_var_type inputVar;
        flow_unit_type flowUnit;
        logic signed [31:0] lowerRange;
        logic signed [31:0] upperRange;
        logic [5:0] dampSec;
    } config_type;

    localparam config_type CFG_RESET = '{
        enable: 1'b1, sigKind: SIG_STATIC, polarity: POL_HIGH, triggerUse: USE_RANGE_SWITCH,
        maxFreq: MAXF_MAX, decimals: DEC_RST, inputVar: VAR_FREQUENCY, flowUnit: FLOW_L_S,
        lowerRange: LRV_RST, upperRange: URV_RST, dampSec: DAMP_RST};

    typedef struct packed {
        logic rangeSwitch;
        logic extHold;
        logic cleanStart;
        logic ctrlEnable;
    } triggers_type;

    typedef struct packed {
        logic [3:0] slotNo;
        logic [3:0] inputNo;
    } chan_id_type;

    typedef struct packed {
        logic valid;
        logic signed [31:0] value;
        logic [1:0] decimals;
        input_var_type inputVar;
        flow_unit_type flowUnit;
        logic [16:0] freqCenti;
    } result_type;

endpackage

// ### design/freq_meter.sv
// Gated pulse counter whose gate and edge spacing scale with the maximum frequency.
`timescale 1ns/1ps
module freq_meter #(
    parameter logic [47:0] GATE_UNITS = 48'(binput_pkg::GATE_UNITS_DEF),
    parameter logic [39:0] EDGE_UNITS = 40'(binput_pkg::EDGE_UNITS_DEF)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic active,
    input wire logic pulseLvl,
    input wire logic [16:0] maxFreq,
    output logic done,
    output logic [10:0] count
);
    import binput_pkg::*;

    typedef struct packed {
        logic prev;
        logic armed;
        logic [47:0] gateAcc;
        logic [39:0] edgeAcc;
        logic [10:0] edges;
        logic done;
        logic [10:0] count;
    } fm_state_type;

    localparam fm_state_type FM_IDLE = '{armed: 1'b1, default: '0};

    fm_state_type s, n;
    logic rise;

    assign rise = pulseLvl & ~s.prev;

    // The gate lasts FULL_SCALE maximum periods, so a count of FULL_SCALE means full scale.
    always_comb begin
        n = s;
        n.done = 1'b0;
        n.prev = pulseLvl;
        if (!active) begin
            n = FM_IDLE;
            n.prev = pulseLvl;
        end else begin
            if (!s.armed) begin
                n.edgeAcc = s.edgeAcc + 40'(maxFreq);
                if (n.edgeAcc >= EDGE_UNITS) begin
                    n.armed = 1'b1;
                end
            end
            // An edge closer than one maximum period is not counted. [R7]
            if (rise && s.armed) begin
                n.armed = 1'b0;
                n.edgeAcc = '0;
                if (s.edges != FULL_SCALE) begin
                    n.edges = s.edges + 11'h001;
                end
            end
            n.gateAcc = s.gateAcc + 48'(maxFreq);
            if (n.gateAcc >= GATE_UNITS) begin // [R8]
                n.done = 1'b1;
                n.count = n.edges;
                n.edges = '0;
                n.gateAcc = '0;
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= FM_IDLE;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
    assign count = s.count;

    property p_fast_edge_ignored;
        @(posedge clk) disable iff (!rst_n)
        active && rise && !s.armed |=> s.done || s.edges == $past(s.edges);
    endproperty
    a_fast_edge_ignored: assert property (p_fast_edge_ignored) else $error("Edge inside spacing was counted."); // [R7]

    property p_count_capped;
        @(posedge clk) disable iff (!rst_n)
        s.done |-> s.count <= FULL_SCALE && s.edges == '0;
    endproperty
    a_count_capped: assert property (p_count_capped) else $error("Gate count exceeds full scale."); // [R8]

endmodule

// ### design/moving_average.sv
// Floating average over the last windowLen samples, or pass-through when windowLen is zero.
`timescale 1ns/1ps
module moving_average #(
    parameter int DEPTH = 64,
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic sampleStb,
    input wire logic signed [W-1:0] sampleIn,
    input wire logic [5:0] windowLen,
    output logic avgStb,
    output logic signed [W-1:0] avgOut
);
    import binput_pkg::*;

    if (DEPTH <= int'(DAMP_MAX) || DEPTH > 64) begin : g_bad_depth
        $error("DEPTH must cover the longest damping window and fit the pointer.");
    end

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [5:0] wp;
        logic [5:0] fill;
        logic signed [W+5:0] sum;
        logic stb;
        logic signed [W-1:0] avg;
    } avg_state_type;

    avg_state_type s, n;
    logic signed [W+5:0] sumNext;
    logic signed [W+5:0] oldest;

    assign oldest = (W+6)'($signed(s.mem[s.wp]));

    // Running sum replaces the oldest sample once the window is full.
    always_comb begin
        n = s;
        n.stb = 1'b0;
        sumNext = s.sum;
        if (clear) begin
            n.wp = '0;
            n.fill = '0;
            n.sum = '0;
        end else if (sampleStb) begin
            n.stb = 1'b1;
            if (windowLen == '0) begin
                n.avg = sampleIn; // [R18]
                n.wp = '0;
                n.fill = '0;
                n.sum = '0;
            end else begin
                if (s.fill >= windowLen) begin
                    sumNext = s.sum - oldest + (W+6)'(sampleIn);
                end else begin
                    sumNext = s.sum + (W+6)'(sampleIn);
                    n.fill = s.fill + 6'h01;
                end
                n.mem[s.wp] = sampleIn;
                n.wp = (s.wp + 6'h01 >= windowLen) ? 6'h00 : s.wp + 6'h01;
                n.sum = sumNext;
                n.avg = W'(sumNext / $signed({1'b0, n.fill})); // [R15]
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign avgStb = s.stb;
    assign avgOut = s.avg;

    property p_zero_window_passes;
        @(posedge clk) disable iff (!rst_n)
        sampleStb && !clear && windowLen == '0 |=> avgStb && avgOut == $past(sampleIn);
    endproperty
    a_zero_window_passes: assert property (p_zero_window_passes) else $error("Undamped sample altered."); // [R18]

endmodule

// ### design/binary_input_pulse_freq_readout.sv
// One binary input channel: static level trigger or pulse-frequency process value.
//
// Contract
// R1: Disabled channel gives no state or value.
// R2: Static or pulse-frequency mode, static after reset.
// R3: Static polarity low or high, high default.
// R4: Asserted level drives range, hold, clean, controller.
// R5: Pulse mode measures frequency as process value.
// R6: Maximum frequency 100 to 1000 Hz, default 1000.
// R7: Pulses above the maximum are not counted.
// R8: Resolution scales with the configured maximum.
// R9: Zero to three decimals, two by default.
// R10: Report frequency, named parameter or flow rate.
// R11: Parameter name and unit, sixteen characters.
// R12: Seven flow units, litres per second default.
// R13: Lower range -2000 to 0 at 0 Hz.
// R14: Upper range 0 to 10000 at maximum.
// R15: Damping 0 to 60 s floating average.
// R16: Channel identified by slot and input number.
// R17: Scaled value interpolates linearly between endpoints.
// R18: Zero damping passes values through unchanged.
`timescale 1ns/1ps
module binary_input_pulse_freq_readout #(
    parameter logic [3:0] SLOT_NO = 4'h1,
    parameter logic [3:0] INPUT_NO = 4'h1,
    parameter logic [47:0] GATE_UNITS = 48'(binput_pkg::GATE_UNITS_DEF),
    parameter logic [39:0] EDGE_UNITS = 40'(binput_pkg::EDGE_UNITS_DEF),
    parameter logic [23:0] SECOND_CYCLES = 24'(binput_pkg::SECOND_CYCLES_DEF)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pinIn,
    input wire logic cfgLoad,
    input wire binput_pkg::config_type cfgIn,
    input wire logic textLoad,
    input wire binput_pkg::text_type nameIn,
    input wire binput_pkg::text_type unitIn,
    output binput_pkg::config_type cfgActive,
    output binput_pkg::text_type paramName,
    output binput_pkg::text_type paramUnit,
    output binput_pkg::triggers_type triggers,
    output binput_pkg::result_type result,
    output binput_pkg::chan_id_type chanId
);
    import binput_pkg::*;

    // Zero timing figures would stall the gate, the edge spacing or the damping clock.
    if (SECOND_CYCLES == 24'h0 || EDGE_UNITS == 40'h0 || GATE_UNITS < 48'(EDGE_UNITS)) begin : g_bad_timing
        $error("Timing parameters must be nonzero and the gate at least one edge spacing.");
    end

    localparam chan_id_type ID_VALUE = '{slotNo: SLOT_NO, inputNo: INPUT_NO};
    localparam logic signed [47:0] FULL_DIV = 48'(FULL_SCALE);
    localparam logic [27:0] FULL_DIV_U = 28'(FULL_SCALE);

    typedef struct packed {
        config_type cfg;
        logic loaded;
        text_type name;
        text_type unit;
        logic sync1;
        logic sync2;
        logic [23:0] secCnt;
        logic secTick;
        logic signed [31:0] procValue;
        logic haveValue;
        triggers_type trig;
        result_type res;
        chan_id_type id;
    } state_type;

    localparam state_type ST_RESET = '{cfg: CFG_RESET, id: ID_VALUE, default: '0};

    state_type s, n;

    logic staticOn;
    logic pulseOn;
    logic levelHit;
    logic measDone;
    logic [10:0] measCount;
    logic signed [32:0] span;
    logic signed [47:0] prod;
    logic signed [31:0] scaled;
    logic [16:0] freqCenti;
    logic signed [31:0] procNow;
    logic avgStbIn;
    logic signed [31:0] avgIn;
    logic avgClear;
    logic avgStb;
    logic signed [31:0] avgOut;

    // Clamp a signed setting into its allowed range.
    function automatic logic signed [31:0] clampS(logic signed [31:0] v, logic signed [31:0] lo,
                                                  logic signed [31:0] hi);
        logic signed [31:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Out-of-range numbers are pulled to the nearest legal value and bad unit or variable codes reset to their defaults,
    // rather than refused, so a careless write never leaves the channel in an undefined mode.
    function automatic config_type sanitize(config_type c);
        config_type r;
        r = c;
        if (c.maxFreq < MAXF_MIN) begin
            r.maxFreq = MAXF_MIN;
        end else if (c.maxFreq > MAXF_MAX) begin
            r.maxFreq = MAXF_MAX;
        end
        r.lowerRange = clampS(c.lowerRange, LRV_MIN, LRV_MAX);
        r.upperRange = clampS(c.upperRange, URV_MIN, URV_MAX);
        if (c.dampSec > DAMP_MAX) begin
            r.dampSec = DAMP_MAX;
        end
        if (c.flowUnit > FLOW_MGD) begin
            r.flowUnit = FLOW_L_S;
        end
        if (c.inputVar > VAR_FLOW) begin
            r.inputVar = VAR_FREQUENCY;
        end
        return r;
    endfunction

    // Values are held in hundredths; shift them to the chosen number of decimals.
    function automatic logic signed [31:0] formatValue(logic signed [31:0] v, logic [1:0] dec);
        logic signed [31:0] r;
        case (dec)
            2'h0: begin
                r = v / STEP_UNIT;
            end
            2'h1: begin
                r = v / STEP_TENTH;
            end
            2'h2: begin
                r = v;
            end
            default: begin
                r = v * STEP_TENTH;
            end
        endcase
        return r;
    endfunction

    // Mode decode from the active configuration.
    assign staticOn = s.cfg.enable && s.cfg.sigKind == SIG_STATIC; // [R1] [R2]
    assign pulseOn = s.cfg.enable && s.cfg.sigKind == SIG_PULSE_FREQ; // [R1] [R5]

    // Only the second synchroniser stage is looked at.
    assign levelHit = staticOn && (s.sync2 == (s.cfg.polarity == POL_HIGH)); // [R3]

    freq_meter #(
        .GATE_UNITS(GATE_UNITS),
        .EDGE_UNITS(EDGE_UNITS)
    ) u_meter (
        .clk(clk),
        .rst_n(rst_n),
        .active(pulseOn),
        .pulseLvl(s.sync2),
        .maxFreq(s.cfg.maxFreq),
        .done(measDone),
        .count(measCount)
    );

    // Linear map: zero count gives the lower value, full scale gives the upper value.
    assign span = 33'(s.cfg.upperRange) - 33'(s.cfg.lowerRange);
    assign prod = span * $signed({1'b0, measCount});
    assign scaled = 32'(48'(s.cfg.lowerRange) + prod / FULL_DIV); // [R13] [R14] [R17]

    // Frequency in hundredths of a hertz; the step is maxFreq over FULL_SCALE. [R8]
    assign freqCenti = 17'((28'(measCount) * 28'(s.cfg.maxFreq)) / FULL_DIV_U);

    // Pick the reported quantity. [R10]
    assign procNow = (s.cfg.inputVar == VAR_FREQUENCY) ? $signed({15'h0, freqCenti}) : scaled;

    // Damped samples are taken once a second so the window length is in seconds;
    // without damping every gate result goes straight through.
    assign avgStbIn = pulseOn && ((s.cfg.dampSec == '0) ? measDone : (s.secTick && s.haveValue)); // [R15]
    assign avgIn = (s.cfg.dampSec == '0) ? procNow : s.procValue; // [R18]
    assign avgClear = cfgLoad || !pulseOn;

    moving_average #(
        .DEPTH(64),
        .W(32)
    ) u_avg (
        .clk(clk),
        .rst_n(rst_n),
        .clear(avgClear),
        .sampleStb(avgStbIn),
        .sampleIn(avgIn),
        .windowLen(s.cfg.dampSec),
        .avgStb(avgStb),
        .avgOut(avgOut)
    );

    // Next-state logic for the whole channel.
    always_comb begin
        n = s;
        n.sync1 = pinIn;
        n.sync2 = s.sync1;
        n.id = ID_VALUE; // [R16]

        // Settings take effect together so mode and range never mix old and new.
        if (cfgLoad) begin
            n.cfg = sanitize(cfgIn); // [R6] [R12] [R13] [R14] [R15]
            n.loaded = 1'b1;
        end
        if (textLoad) begin
            n.name = nameIn; // [R11]
            n.unit = unitIn; // [R11]
        end

        // One-second time base for the damping window.
        n.secTick = 1'b0;
        if (s.secCnt >= SECOND_CYCLES - 24'h1) begin
            n.secCnt = '0;
            n.secTick = 1'b1;
        end else begin
            n.secCnt = s.secCnt + 24'h1;
        end

        // The asserted level goes to the one consumer chosen for this channel.
        n.trig = '0;
        if (levelHit) begin
            case (s.cfg.triggerUse)
                USE_RANGE_SWITCH: begin
                    n.trig.rangeSwitch = 1'b1; // [R4]
                end
                USE_EXT_HOLD: begin
                    n.trig.extHold = 1'b1; // [R4]
                end
                USE_CLEANING: begin
                    n.trig.cleanStart = 1'b1; // [R4]
                end
                default: begin
                    n.trig.ctrlEnable = 1'b1; // [R4]
                end
            endcase
        end

        // Latest gate result is kept for the damping sampler.
        if (measDone) begin
            n.procValue = procNow; // [R5]
            n.haveValue = 1'b1;
            n.res.freqCenti = freqCenti;
        end
        if (avgStb) begin
            n.res.value = formatValue(avgOut, s.cfg.decimals); // [R9]
            n.res.valid = 1'b1;
        end
        n.res.decimals = s.cfg.decimals; // [R9]
        n.res.inputVar = s.cfg.inputVar; // [R10]
        n.res.flowUnit = s.cfg.flowUnit; // [R12]

        // A channel that is off or static shows no measured value.
        if (!pulseOn) begin
            n.res = '0; // [R1]
            n.haveValue = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= ST_RESET;
        end else begin
            s <= n;
        end
    end

    // Every output is a field of the state register.
    assign cfgActive = s.cfg;
    assign paramName = s.name;
    assign paramUnit = s.unit;
    assign triggers = s.trig;
    assign result = s.res;
    assign chanId = s.id;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_static_hit;
        s.cfg.enable && s.cfg.sigKind == SIG_STATIC && s.sync2 == (s.cfg.polarity == POL_HIGH);
    endsequence

    sequence s_undamped_result;
        measDone && pulseOn && s.cfg.dampSec == '0 && !cfgLoad ##1 !cfgLoad;
    endsequence

    property p_disabled_quiet;
        !s.cfg.enable |=> triggers == '0 && result == '0;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled channel produced output."); // [R1]

    property p_reset_defaults;
        !s.loaded |-> s.cfg == CFG_RESET && s.cfg.sigKind == SIG_STATIC;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("Settings differ from reset values."); // [R2]

    property p_polarity;
        s_static_hit |=> triggers != '0;
    endproperty
    a_polarity: assert property (p_polarity) else $error("Asserted level gave no trigger."); // [R3]

    property p_inactive_level;
        staticOn && !levelHit |=> triggers == '0;
    endproperty
    a_inactive_level: assert property (p_inactive_level) else $error("Inactive level gave a trigger."); // [R3]

    property p_clean_route;
        s_static_hit and (s.cfg.triggerUse == USE_CLEANING) |=> triggers.cleanStart && !triggers.extHold;
    endproperty
    a_clean_route: assert property (p_clean_route) else $error("Cleaning trigger misrouted."); // [R4]

    property p_maxfreq_range;
        s.cfg.maxFreq >= MAXF_MIN && s.cfg.maxFreq <= MAXF_MAX;
    endproperty
    a_maxfreq_range: assert property (p_maxfreq_range) else $error("Maximum frequency out of range."); // [R6]

    property p_range_limits;
        s.cfg.lowerRange >= LRV_MIN && s.cfg.lowerRange <= LRV_MAX
            && s.cfg.upperRange >= URV_MIN && s.cfg.upperRange <= URV_MAX;
    endproperty
    a_range_limits: assert property (p_range_limits) else $error("Range endpoint out of limits."); // [R13] [R14]

    property p_zero_count_lower;
        measDone && measCount == '0 |-> scaled == s.cfg.lowerRange;
    endproperty
    a_zero_count_lower: assert property (p_zero_count_lower) else $error("Zero count not at lower value."); // [R17]

    property p_undamped_latency;
        s_undamped_result |=> result.valid && result.decimals == $past(s.cfg.decimals);
    endproperty
    a_undamped_latency: assert property (p_undamped_latency) else $error("Undamped result late."); // [R18]

    property p_channel_id;
        chanId == ID_VALUE;
    endproperty
    a_channel_id: assert property (p_channel_id) else $error("Channel identity wrong."); // [R16]

endmodule

// ### bench/pulse_source.sv
// Pulse train source standing in for a flowmeter output.
`timescale 1ns/1ps
module pulse_source (
    input wire logic clk,
    input wire logic run,
    input wire logic [7:0] halfPeriod,
    output logic pulseOut
);
    logic [7:0] cnt;
    initial begin
        cnt = 8'h00;
        pulseOut = 1'b0;
    end
    // Stopped source sits low, as a pulled-down open collector would.
    always @(posedge clk) begin
        if (!run) begin
            cnt <= 8'h00;
            pulseOut <= 1'b0;
        end else if (cnt == halfPeriod - 8'h01) begin
            cnt <= 8'h00;
            pulseOut <= !pulseOut;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule

// ### bench/testbench.sv
// Self-checking bench for one binary input readout channel.
`timescale 1ns/1ps
module testbench;
    import binput_pkg::*;
    typedef struct packed {
        polarity_type pol;
        trigger_use_type useSel;
        logic pin;
        triggers_type exp;
    } row_type;
    logic clk, rst_n, level, pulseOut, run, cfgLoad, textLoad;
    logic [7:0] halfPeriod;
    config_type cfgIn, cfgActive, c;
    text_type nameIn, unitIn, paramName, paramUnit;
    triggers_type triggers;
    result_type result;
    chan_id_type chanId;
    int errors, check_count;
    row_type rows [6] = '{'{POL_HIGH, USE_RANGE_SWITCH, 1'b1, 4'h8}, '{POL_HIGH, USE_EXT_HOLD, 1'b0, 4'h0},
        '{POL_HIGH, USE_EXT_HOLD, 1'b1, 4'h4}, '{POL_LOW, USE_CLEANING, 1'b0, 4'h2},
        '{POL_LOW, USE_CLEANING, 1'b1, 4'h0}, '{POL_LOW, USE_CTRL_ENABLE, 1'b0, 4'h1}};

    pulse_source src (.clk(clk), .run(run), .halfPeriod(halfPeriod), .pulseOut(pulseOut));

    // Gate of 1000 cycles at full scale keeps the pulse runs short.
    binary_input_pulse_freq_readout #(.SLOT_NO(4'h1), .INPUT_NO(4'h2), .GATE_UNITS(48'h5f5e100),
        .EDGE_UNITS(40'h186a0), .SECOND_CYCLES(24'h32)) dut (.clk(clk), .rst_n(rst_n),
        .pinIn(run ? pulseOut : level), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .textLoad(textLoad),
        .nameIn(nameIn), .unitIn(unitIn), .cfgActive(cfgActive), .paramName(paramName),
        .paramUnit(paramUnit), .triggers(triggers), .result(result), .chanId(chanId));

    task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; leaves time for the pin synchroniser to settle.
    task automatic load(input config_type v);
        cfgIn <= v;
        cfgLoad <= 1'b1;
        @(posedge clk);
        cfgLoad <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Watchdog sized well beyond the pulse runs.
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        level = 1'b0;
        run = 1'b0;
        halfPeriod = 8'h0a;
        cfgLoad = 1'b0;
        textLoad = 1'b0;
        cfgIn = CFG_RESET;
        nameIn = '0;
        unitIn = '0;
        errors = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("cfgActive", CFG_RESET, cfgActive);
        chk("chanId", 8'h12, chanId);
        for (int i = 0; i < 6; i++) begin
            c = CFG_RESET;
            c.polarity = rows[i].pol;
            c.triggerUse = rows[i].useSel;
            level <= rows[i].pin;
            load(c);
            chk("triggers", rows[i].exp, triggers);
        end
        c.enable = 1'b0;
        load(c);
        chk("triggers off", 4'h0, triggers);
        nameIn <= "Pressure";
        unitIn <= "hPa";
        textLoad <= 1'b1;
        @(posedge clk);
        textLoad <= 1'b0;
        @(posedge clk);
        chk("paramName", "Pressure", paramName);
        chk("paramUnit", "hPa", paramUnit);
        // Fifty edges per gate: 50 Hz, scaled onto 0 to 1000.00 with no decimals.
        run <= 1'b1;
        c = CFG_RESET;
        c.sigKind = SIG_PULSE_FREQ;
        c.inputVar = VAR_FLOW;
        c.flowUnit = FLOW_MGD;
        c.upperRange = 32'sh0001_86a0;
        c.decimals = 2'h0;
        load(c);
        repeat (3000) @(posedge clk);
        chk("freqCenti", 17'h01388, result.freqCenti);
        chk("value", 32'h0000_0032, result.value);
        chk("flowUnit", FLOW_MGD, result.flowUnit);
        chk("valid", 1'b1, result.valid);
        c.sigKind = SIG_STATIC;
        load(c);
        chk("valid static", 1'b0, result.valid);
        // Edges every 4 cycles against a 5-cycle spacing at 200 Hz: only every other edge counts.
        run <= 1'b0;
        halfPeriod <= 8'h02;
        @(posedge clk);
        run <= 1'b1;
        c.sigKind = SIG_PULSE_FREQ;
        c.maxFreq = 17'h04e20;
        c.decimals = 2'h3;
        load(c);
        repeat (5100) @(posedge clk);
        chk("freqCenti limited", 17'h030d4, result.freqCenti);
        chk("value three decimals", 32'h0009_8968, result.value);
        // No edges at all must land exactly on the lower range value.
        run <= 1'b0;
        c.maxFreq = MAXF_MAX;
        c.lowerRange = LRV_MIN;
        c.decimals = 2'h2;
        load(c);
        repeat (2100) @(posedge clk);
        chk("freqCenti idle", 17'h00000, result.freqCenti);
        chk("lower value", LRV_MIN, result.value);
        // A changed format only shows once the damped averager has produced a sample.
        c.dampSec = 6'h02;
        c.decimals = 2'h1;
        load(c);
        repeat (200) @(posedge clk);
        chk("damped value", LRV_MIN / STEP_TENTH, result.value);
        tally_and_finish();
    end
endmodule
